/* File: rtl/timer_core.v */
`timescale 1ns/1ps
`include "timer_module_map.vh"
module timer_core #(
    parameter PERIODIC = 1,
    parameter WIDTH = 10
) (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] ticks,
    input wire [7:0] ctrl0,
    input wire [7:0] ctrl1,
    input wire [WIDTH-1:0] ccra,
    input wire [WIDTH-1:0] ccrp,
    input wire ext_clk_pin,
    input wire cap_pin,
    output reg [WIDTH-1:0] cnt_q,
    output reg match_a_q,
    output reg match_p_q,
    output reg cap_q,
    output reg out_q
);
    reg [2:0] ck_s_q;
    reg [2:0] cp_s_q;
    reg on_q;
    reg sp_q;
    reg tick;
    reg cap_ev;
    wire on = ctrl0[`F_ON];
    wire [2:0] cks = ctrl0[`F_CKS_HI:`F_CKS_LO];
    wire [1:0] mode = ctrl1[`F_MODE_HI:`F_MODE_LO];
    wire [1:0] io = ctrl1[`F_IO_HI:`F_IO_LO];
    wire oc = ctrl1[`F_OC];
    wire dpx = ctrl1[`F_DPX];
    wire ck_rise = ck_s_q[1] & ~ck_s_q[2];
    wire ck_fall = ~ck_s_q[1] & ck_s_q[2];
    wire cp_rise = cp_s_q[1] & ~cp_s_q[2];
    wire cp_fall = ~cp_s_q[1] & cp_s_q[2];
    wire pwm = (mode == `MODE_PWM);
    wire single = (PERIODIC != 0) && pwm && (io == `IO_SINGLE);
    wire a_hit = (cnt_q == ccra);
    wire p_hit = (ccrp == {WIDTH{1'b0}}) ? &cnt_q : (cnt_q == ccrp);
    wire clr_hit = pwm ? (dpx ? a_hit : p_hit)
                       : (ctrl1[`F_CCLR] ? a_hit : p_hit);
    wire [WIDTH-1:0] duty = dpx ? ccrp : ccra;
    wire act = (cnt_q < duty) & (~single | sp_q);
    wire run = on & ~ctrl0[`F_PAUSE] & (~single | sp_q);
    wire step = run & tick;

    // counter clock choice
    always @* begin
        case (cks)
            `CKS_SYS4: tick = ticks[0]; // [RULE5]
            `CKS_SYS: tick = ticks[1];
            `CKS_H16: tick = ticks[2];
            `CKS_H64: tick = ticks[3];
            `CKS_SUB0, `CKS_SUB1: tick = ticks[4];
            `CKS_EXT_RISE: tick = ck_rise & ~single; // [RULE6]
            default: tick = ck_fall & ~single;
        endcase
    end

    // capture edge choice
    always @* begin
        case (io)
            `CAP_RISE: cap_ev = cp_rise; // [RULE8]
            `CAP_FALL: cap_ev = cp_fall;
            `CAP_BOTH: cap_ev = cp_rise | cp_fall;
            default: cap_ev = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ck_s_q <= 3'h0;
            cp_s_q <= 3'h0;
            on_q <= 1'b0;
            sp_q <= 1'b0;
            cnt_q <= {WIDTH{1'b0}};
            match_a_q <= 1'b0;
            match_p_q <= 1'b0;
            cap_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            ck_s_q <= {ck_s_q[1:0], ext_clk_pin}; // [RULE15]
            cp_s_q <= {cp_s_q[1:0], cap_pin}; // [RULE15]
            on_q <= on;
            match_a_q <= step & a_hit; // [RULE4]
            match_p_q <= step & p_hit; // [RULE4]
            cap_q <= (PERIODIC != 0) & on & (mode == `MODE_CAP) & cap_ev;
            if (on & ~on_q) begin
                cnt_q <= {WIDTH{1'b0}};
                out_q <= oc;
                sp_q <= 1'b0;
            end else begin
                if (step) begin
                    if (clr_hit) begin
                        cnt_q <= {WIDTH{1'b0}}; // [RULE3]
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                if (single & on) begin
                    if (ck_rise & ~sp_q) begin
                        sp_q <= 1'b1; // [RULE7]
                        cnt_q <= {WIDTH{1'b0}};
                    end else if (step & p_hit) begin
                        sp_q <= 1'b0;
                    end
                end
                case (mode)
                    `MODE_CMP: begin
                        if (step & a_hit) begin
                            case (io)
                                `IO_LOW: out_q <= 1'b0; // [RULE10]
                                `IO_HIGH: out_q <= 1'b1;
                                `IO_TOGGLE: out_q <= ~out_q;
                                default: out_q <= out_q;
                            endcase
                        end
                    end
                    `MODE_PWM: begin
                        if (on) begin
                            out_q <= act ? oc : ~oc; // [RULE11]
                        end
                    end
                    default: out_q <= out_q;
                endcase
            end
        end
    end
endmodule

/* File: rtl/timer_module.v */
// Functional notes
// [RULE1] one compact, two periodic 10-bit timers
// [RULE2] capture and single pulse on periodic only
// [RULE3] counter equal comparator raises match, may clear
// [RULE4] two match sources, comparator A and P
// [RULE5] three-bit field picks counter clock source
// [RULE6] external pin counts on chosen edge
// [RULE7] periodic external pin triggers single pulse
// [RULE8] capture edge rising, falling or both
// [RULE9] compact: clock pin; periodic: clock, capture
// [RULE10] compare match sets, clears or toggles output
// [RULE11] primary and inverted output carry PWM
// [RULE12] one select bit per shared output pin
// [RULE13] select one gives pin to timer
// [RULE14] low bytes pass through 8-bit holding buffer
// [RULE15] input pins synchronised before edge detection
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "timer_module_map.vh"
module timer_module #(
    parameter WIDTH = 10,
    parameter SUB_DIV = `SUB_DIV_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire awvalid,
    output wire awready,
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    output wire bvalid,
    input wire bready,
    output wire [1:0] bresp,
    input wire arvalid,
    output wire arready,
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    output wire rvalid,
    input wire rready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    input wire [2:0] timer_ext_clock_pin,
    input wire [1:0] capture_input_pin,
    input wire [5:0] alt_out,
    input wire [5:0] alt_oe,
    output reg [5:0] pin_out,
    output reg [5:0] pin_oe,
    output wire [2:0] match_a,
    output wire [2:0] match_p
);
    localparam integer SUB_LAST_I = SUB_DIV - 1;
    localparam [15:0] SUB_LAST = SUB_LAST_I[15:0];
    integer i;

    reg [7:0] c0_q [0:2];
    reg [7:0] c1_q [0:2];
    reg [WIDTH-1:0] a_q [0:2];
    reg [WIDTH-1:0] rp_q [0:2];
    reg [7:0] buf_q [0:2];
    reg [5:0] psel_q;
    reg [5:0] pin_s_q;
    reg [5:0] pre_q;
    reg [15:0] sub_q;
    reg [4:0] ticks_q;
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] aw_addr_q;
    reg [7:0] w_data_q;
    reg w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [7:0] rd_val;
    wire [WIDTH-1:0] cnt_w [0:2];
    wire [2:0] cap_w;
    wire [2:0] out_w;
    wire [5:0] tm_lvl;

    // address holds a timer register or a common register
    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a == `ADDR_PIN_SEL) || (a == `ADDR_PIN_STAT) ||
                (~a[7] && (a[6:5] != 2'h3) && (a[1:0] == 2'h0) &&
                 ((a[4:3] != 2'h3) || (a[6:5] != 2'h0)));
        end
    endfunction

    wire [1:0] wt = aw_addr_q[`TIMER_IDX_HI:`TIMER_IDX_LO];
    wire [2:0] wr = aw_addr_q[`REG_IDX_HI:`REG_IDX_LO];
    wire [1:0] rt = araddr[`TIMER_IDX_HI:`TIMER_IDX_LO];
    wire [2:0] rr = araddr[`REG_IDX_HI:`REG_IDX_LO];
    wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
    wire wr_ok = addr_ok(aw_addr_q);
    wire do_rd = arvalid & ~rvalid_q;
    wire rd_ok = addr_ok(araddr);
    wire rd_tmr = rd_ok & ~araddr[7];

    assign awready = ~aw_got_q & ~bvalid_q;
    assign wready = ~w_got_q & ~bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // prescaler and sub clock enables
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 6'h00;
            sub_q <= 16'h0000;
            ticks_q <= 5'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
            if (sub_q == SUB_LAST) begin
                sub_q <= 16'h0000;
            end else begin
                sub_q <= sub_q + 16'h0001;
            end
            ticks_q[0] <= (pre_q & `PRE_SYS4_MASK) == `PRE_SYS4_MASK;
            ticks_q[1] <= 1'b1;
            ticks_q[2] <= (pre_q & `PRE_H16_MASK) == `PRE_H16_MASK;
            ticks_q[3] <= (pre_q & `PRE_H64_MASK) == `PRE_H64_MASK;
            ticks_q[4] <= (sub_q == SUB_LAST);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : tmr
            wire [WIDTH-1:0] ccrp;
            wire cap_in;
            if (g == 0) begin : cmp
                assign ccrp = {c0_q[g][`F_RP3_HI:0],
                               {(WIDTH-3){1'b0}}};
                assign cap_in = 1'b0; // [RULE9]
            end else begin : per
                assign ccrp = rp_q[g];
                assign cap_in = capture_input_pin[g-1]; // [RULE9]
            end
            timer_core #(
                .PERIODIC(g != 0), // [RULE1] [RULE2]
                .WIDTH(WIDTH)
            ) u_core (
                .aclk(aclk),
                .aresetn(aresetn),
                .ticks(ticks_q),
                .ctrl0(c0_q[g]),
                .ctrl1(c1_q[g]),
                .ccra(a_q[g]),
                .ccrp(ccrp),
                .ext_clk_pin(timer_ext_clock_pin[g]),
                .cap_pin(cap_in),
                .cnt_q(cnt_w[g]),
                .match_a_q(match_a[g]),
                .match_p_q(match_p[g]),
                .cap_q(cap_w[g]),
                .out_q(out_w[g])
            );
            assign tm_lvl[2*g] = out_w[g] ^ c1_q[g][`F_POL];
            assign tm_lvl[2*g+1] = ~tm_lvl[2*g]; // [RULE11]
        end
    endgenerate

    // read data selection
    always @* begin
        rd_val = 8'h00;
        if (araddr == `ADDR_PIN_SEL) begin
            rd_val = {2'h0, psel_q};
        end else if (araddr == `ADDR_PIN_STAT) begin
            rd_val = {2'h0, pin_s_q};
        end else if (rd_tmr) begin
            case (rr)
                `REG_CTRL0: rd_val = c0_q[rt];
                `REG_CTRL1: rd_val = c1_q[rt];
                `REG_CNT_HI: rd_val = {6'h00, cnt_w[rt][WIDTH-1:8]};
                `REG_CMPA_HI: rd_val = {6'h00, a_q[rt][WIDTH-1:8]};
                `REG_CMPP_HI: rd_val = {6'h00, rp_q[rt][WIDTH-1:8]};
                default: rd_val = buf_q[rt]; // [RULE14]
            endcase
        end
    end

    // bus slave and register file
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `RESP_OKAY;
            psel_q <= `RST_PIN_SEL;
            pin_s_q <= 6'h00;
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
            for (i = 0; i < 3; i = i + 1) begin
                c0_q[i] <= `RST_CTRL;
                c1_q[i] <= `RST_CTRL;
                a_q[i] <= `RST_CMP;
                rp_q[i] <= `RST_CMP;
                buf_q[i] <= 8'h00;
            end
        end else begin
            pin_s_q <= tm_lvl;
            for (i = 0; i < 6; i = i + 1) begin
                pin_out[i] <= psel_q[i] ? tm_lvl[i] : alt_out[i]; // [RULE12]
                pin_oe[i] <= psel_q[i] | alt_oe[i]; // [RULE13]
            end
            if (awvalid & awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid & wready) begin
                w_got_q <= 1'b1;
                w_data_q <= wdata[7:0];
                w_strb_q <= wstrb[0];
            end
            if (bvalid_q & bready) begin
                bvalid_q <= 1'b0;
            end
            if (rvalid_q & rready) begin
                rvalid_q <= 1'b0;
            end
            if (do_rd) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_val};
                rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (rd_tmr) begin
                    case (rr)
                        `REG_CNT_HI: buf_q[rt] <= cnt_w[rt][7:0]; // [RULE14]
                        `REG_CMPA_HI: buf_q[rt] <= a_q[rt][7:0]; // [RULE14]
                        `REG_CMPP_HI: buf_q[rt] <= rp_q[rt][7:0]; // [RULE14]
                        default: buf_q[rt] <= buf_q[rt];
                    endcase
                end
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_ok & w_strb_q) begin
                    if (aw_addr_q == `ADDR_PIN_SEL) begin
                        psel_q <= w_data_q[5:0]; // [RULE12]
                    end else if (~aw_addr_q[7]) begin
                        case (wr)
                            `REG_CTRL0: c0_q[wt] <= w_data_q; // [RULE5]
                            `REG_CTRL1: c1_q[wt] <= w_data_q;
                            `REG_CNT_HI: c0_q[wt] <= c0_q[wt];
                            `REG_CMPA_HI:
                                a_q[wt] <= {w_data_q[1:0], buf_q[wt]}; // [RULE14]
                            `REG_CMPP_HI:
                                rp_q[wt] <= {w_data_q[1:0], buf_q[wt]}; // [RULE14]
                            default: buf_q[wt] <= w_data_q; // [RULE14]
                        endcase
                    end
                end
            end
            for (i = 1; i < 3; i = i + 1) begin
                if (cap_w[i]) begin
                    a_q[i] <= cnt_w[i]; // [RULE2] [RULE8]
                end
            end
        end
    end
endmodule

/* File: rtl/timer_module_map.vh */
`ifndef TIMER_MODULE_MAP_VH
`define TIMER_MODULE_MAP_VH
// register index inside one timer window
`define REG_CTRL0 3'h0
`define REG_CTRL1 3'h1
`define REG_CNT_LO 3'h2
`define REG_CNT_HI 3'h3
`define REG_CMPA_LO 3'h4
`define REG_CMPA_HI 3'h5
`define REG_CMPP_LO 3'h6
`define REG_CMPP_HI 3'h7
// address fields
`define TIMER_IDX_HI 6
`define TIMER_IDX_LO 5
`define REG_IDX_HI 4
`define REG_IDX_LO 2
`define ADDR_PIN_SEL 8'h80
`define ADDR_PIN_STAT 8'h84
// control 0 fields
`define F_PAUSE 7
`define F_CKS_HI 6
`define F_CKS_LO 4
`define F_ON 3
`define F_RP3_HI 2
// control 1 fields
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_IO_HI 5
`define F_IO_LO 4
`define F_OC 3
`define F_POL 2
`define F_DPX 1
`define F_CCLR 0
// reset values
`define RST_CTRL 8'h00
`define RST_CMP 10'h000
`define RST_PIN_SEL 6'h00
// operating modes
`define MODE_CMP 2'h0
`define MODE_CAP 2'h1
`define MODE_PWM 2'h2
`define MODE_TMR 2'h3
// counter clock selects
`define CKS_SYS4 3'h0
`define CKS_SYS 3'h1
`define CKS_H16 3'h2
`define CKS_H64 3'h3
`define CKS_SUB0 3'h4
`define CKS_SUB1 3'h5
`define CKS_EXT_RISE 3'h6
`define CKS_EXT_FALL 3'h7
// compare output actions
`define IO_HOLD 2'h0
`define IO_LOW 2'h1
`define IO_HIGH 2'h2
`define IO_TOGGLE 2'h3
// capture edges, single pulse select
`define CAP_RISE 2'h0
`define CAP_FALL 2'h1
`define CAP_BOTH 2'h2
`define IO_SINGLE 2'h3
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// timing
`define SYS_CLK_HZ 25000000
`define SUB_CLK_HZ 32768
`define SUB_DIV_CYCLES (`SYS_CLK_HZ / `SUB_CLK_HZ)
`define PRE_SYS4_MASK 6'h03
`define PRE_H16_MASK 6'h0F
`define PRE_H64_MASK 6'h3F
`endif

/* File: tb/timer_module_properties.sv */
`timescale 1ns/1ps
module timer_module_checker (
    input wire aclk,
    input wire aresetn,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid,
    input wire bready,
    input wire [1:0] bresp,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata,
    input wire [5:0] alt_out,
    input wire [5:0] alt_oe,
    input wire [5:0] pin_out,
    input wire [5:0] pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_w_block;
        bvalid |-> !awready && !wready;
    endproperty
    a_w_block: assert property (p_w_block)
        else $error("write accepted while response pending");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_b_after;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response late");
    property p_r_after;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read data late");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_r_byte;
        rvalid |-> rdata[31:8] == 24'h000000;
    endproperty
    a_r_byte: assert property (p_r_byte)
        else $error("read data wider than a byte");
    property p_pin_oe;
        $past(aresetn) |-> (~pin_oe & $past(alt_oe)) == 6'h00;
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("shared pin enable lost");
    property p_pin_out;
        $past(aresetn) |-> ((pin_out ^ $past(alt_out)) & ~pin_oe) == 6'h00;
    endproperty
    a_pin_out: assert property (p_pin_out)
        else $error("unselected pin not passed through");
endmodule

bind timer_module timer_module_checker checker_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .alt_out(alt_out), .alt_oe(alt_oe),
    .pin_out(pin_out), .pin_oe(pin_oe)
);

/* File: tb/timer_module_test.sv */
`timescale 1ns/1ps
module timer_module_test;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, v;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'h0;
    reg [5:0] alt_out = 6'h00, alt_oe = 6'h00;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp, cap;
    wire [31:0] rdata;
    wire [5:0] pin_out, pin_oe;
    wire [2:0] match_a, match_p, ext_clk;
    int mismatches = 0, n_checks = 0, na = 0, np = 0, nh = 0, i, k, kp, kh;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];

    always #20 aclk = ~aclk;

    timer_module #(.SUB_DIV(4)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .timer_ext_clock_pin(ext_clk),
        .capture_input_pin(cap), .alt_out(alt_out), .alt_oe(alt_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .match_a(match_a),
        .match_p(match_p)
    );
    timer_pins_model partner_u (.aclk(aclk), .ext_clk(ext_clk), .cap(cap));

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input [33:0] e, input [33:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task lim(input int n);
        if (n >= 300) begin
            mismatches++;
            test_done();
        end
    endtask

    task wr(input [7:0] a, input [7:0] d, input [1:0] r);
        int n;
        n = 0;
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 300);
        bready <= 1'b0;
        lim(n);
    endtask

    task rd(input [7:0] a, input [7:0] e, input [1:0] r);
        int n;
        n = 0;
        exp_r.push_back({r, 24'h000000, e});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 300);
        rready <= 1'b0;
        lim(n);
    endtask

    // response watcher and shared-pin stimulus
    always @(posedge aclk) begin
        if (aresetn && bvalid && bready)
            chk("bresp", exp_b.pop_front(), bresp);
        if (aresetn && rvalid && rready)
            chk("rdata", exp_r.pop_front(), {rresp, rdata});
        na <= na + match_a[1];
        np <= np + match_p[1];
        nh <= nh + pin_out[2];
        alt_out <= 6'($urandom);
        alt_oe <= 6'($urandom);
    end

    initial begin
        void'($urandom(24));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 8'h00, 2'h0);
        rd(8'h24, 8'h00, 2'h0);
        rd(8'h80, 8'h00, 2'h0);
        rd(8'h18, 8'h00, 2'h2);
        wr(8'h1C, 8'h01, 2'h2);
        v = 8'($urandom);
        wr(8'h30, v, 2'h0);
        rd(8'h34, 8'h00, 2'h0);
        rd(8'h30, 8'h00, 2'h0);
        wr(8'h30, v, 2'h0);
        wr(8'h34, 8'h02, 2'h0);
        rd(8'h34, 8'h02, 2'h0);
        rd(8'h30, v, 2'h0);
        // timer one toggles on compare A, clears there
        wr(8'h30, 8'h05, 2'h0);
        wr(8'h34, 8'h00, 2'h0);
        wr(8'h80, 8'h0C, 2'h0);
        wr(8'h24, 8'h31, 2'h0);
        k = na;
        wr(8'h20, 8'h18, 2'h0);
        repeat (60) @(posedge aclk);
        wr(8'h20, 8'h98, 2'h0);
        repeat (4) @(posedge aclk);
        k = na - k;
        chk("match_a", 34'h1, (k >= 8 && k <= 12));
        chk("match_p", 34'h0, np);
        chk("pins", {2'b11, ~k[0], k[0]},
            {pin_oe[3:2], pin_out[3:2]});
        // timer one single pulse: period 8, duty 3, pin trigger
        wr(8'h38, 8'h08, 2'h0);
        wr(8'h3C, 8'h00, 2'h0);
        wr(8'h30, 8'h03, 2'h0);
        wr(8'h34, 8'h00, 2'h0);
        wr(8'h24, 8'hB8, 2'h0);
        wr(8'h20, 8'h18, 2'h0);
        k = na;
        kp = np;
        kh = nh;
        repeat (20) @(posedge aclk);
        partner_u.pulses(1, 1);
        repeat (20) @(posedge aclk);
        chk("pulse_p", 34'h1, np - kp);
        chk("pulse_a", 34'h1, na - k);
        chk("pulse_width", 34'h3, nh - kh);
        chk("pulse_idle", 34'h2, pin_out[3:2]);
        // timer zero counts pin edges, rising then falling
        for (i = 6; i < 8; i++) begin
            wr(8'h00, 8'h00, 2'h0);
            wr(8'h00, 8'(i * 16 + 8), 2'h0);
            partner_u.pulses(0, i + 1);
            repeat (6) @(posedge aclk);
            rd(8'h0C, 8'h00, 2'h0);
            rd(8'h08, 8'(i + 1), 2'h0);
        end
        // timer two captures its pin-counted value
        for (i = 0; i < 3; i++) begin
            wr(8'h40, 8'h00, 2'h0);
            wr(8'h44, 8'(64 + i * 16), 2'h0);
            wr(8'h40, 8'h68, 2'h0);
            partner_u.pulses(2, 2);
            partner_u.set_cap(1, 1'b1);
            partner_u.pulses(2, 2);
            partner_u.set_cap(1, 1'b0);
            partner_u.pulses(2, 1);
            rd(8'h54, 8'h00, 2'h0);
            rd(8'h50, (i == 0) ? 8'h02 : 8'h04, 2'h0);
        end
        test_done();
    end
endmodule

/* File: tb/timer_pins_model.sv */
`timescale 1ns/1ps
module timer_pins_model (
    input wire aclk,
    output reg [2:0] ext_clk,
    output reg [1:0] cap
);
    initial begin
        ext_clk = 3'h0;
        cap = 2'h0;
    end
    // clean pulses, idle low between bursts
    task pulses(input int idx, input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_clk[idx] <= 1'b1;
            repeat (3) @(posedge aclk);
            ext_clk[idx] <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask
    // level held past the input synchroniser
    task set_cap(input int idx, input bit lvl);
        @(posedge aclk);
        cap[idx] <= lvl;
        repeat (3) @(posedge aclk);
    endtask
endmodule
